/* File: rsx_alu.sv */
`timescale 1ns/1ps
module rsx_alu (
  // Operation
  input rsx_pkg::rsx_op_t op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic [2:0] cnt_i,
  input rsx_pkg::rsx_flags_t flg_i,
  // Result
  output logic [7:0] res_o,
  output rsx_pkg::rsx_flags_t flg_o
);
  import rsx_pkg::*;

  logic [8:0] diff;
  logic [15:0] wide;
  logic brw;

  // Arithmetic, logic and shift datapath
  always_comb begin
    res_o = a_i;
    flg_o = flg_i;
    diff = '0;
    wide = '0;
    brw = (op_i == OP_MINUS_BORROW_ACC) & flg_i.c;
    case (op_i)
      OP_SUB_IMM, OP_MINUS_ACC, OP_MINUS_BORROW_ACC: begin
        diff = {1'b0, a_i} - {1'b0, b_i} - {8'h00, brw};
        res_o = diff[7:0];
        flg_o.c = diff[8];
        flg_o.v = (a_i[7] ^ b_i[7]) & (a_i[7] ^ diff[7]);
      end
      OP_XOR_IMM, OP_EXCLUSIVE_OR_ACC: begin
        res_o = a_i ^ b_i;
      end
      OP_CIRC_RIGHT: begin
        wide = {a_i, a_i} >> cnt_i;
        res_o = wide[7:0];
        if (cnt_i != 3'h0) begin
          flg_o.c = wide[7];
        end
      end
      OP_LEFT_SHIFT: begin
        wide = {8'h00, a_i} << cnt_i;
        res_o = wide[7:0];
        if (cnt_i != 3'h0) begin
          flg_o.c = wide[8];
        end
      end
      OP_RIGHT_SHIFT: begin
        wide = {a_i, 8'h00} >> cnt_i;
        res_o = wide[15:8];
        if (cnt_i != 3'h0) begin
          flg_o.c = wide[7];
        end
      end
      default: ;
    endcase
    // Sign and zero from the result byte
    if (op_i != OP_POP_JUMP && op_i != OP_TRAP) begin
      flg_o.n = res_o[7];
      flg_o.z = (res_o == 8'h00);
    end
  end

endmodule : rsx_alu

/* File: rsx_core.sv */
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module rsx_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input rsx_pkg::rsx_wb_req_t wb_req_i,
  output rsx_pkg::rsx_wb_rsp_t wb_rsp_o,
  // Receiver and transmitter status
  input rsx_pkg::rsx_xsr_t xmit_status_reg_i,
  // Hardware interrupt requests and acknowledges
  input rsx_pkg::rsx_irq_t irq_req_i,
  output rsx_pkg::rsx_irq_t irq_ack_o,
  // Data memory write port
  output rsx_pkg::rsx_dmem_t dmem_o
);
  import rsx_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } rsx_state_t;

  // Flag selected by a 3-bit code
  function automatic logic cond_pick(input logic [2:0] f,
                                     input rsx_flags_t fl,
                                     input rsx_xsr_t x);
    case (f)
      3'h0: cond_pick = fl.z;
      3'h1: cond_pick = fl.c;
      3'h2: cond_pick = fl.v;
      3'h3: cond_pick = fl.n;
      3'h4: cond_pick = x.rx_active;
      3'h5: cond_pick = x.rx_error;
      3'h6: cond_pick = x.rx_data_ready;
      default: cond_pick = x.tx_queue_full;
    endcase
  endfunction : cond_pick

  // Index address (high half) and updated pointer (low half)
  function automatic logic [31:0] idx_calc(input logic [1:0] mode,
                                           input logic [15:0] p);
    case (mode)
      2'b00: idx_calc = {p, p - 16'h0001};
      2'b01: idx_calc = {p, p};
      2'b10: idx_calc = {p, p + 16'h0001};
      default: idx_calc = {p + 16'h0001, p + 16'h0001};
    endcase
  endfunction : idx_calc

  // Byte-lane merge of a bus write
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : lane_merge

  // Interrupt vector by fixed priority
  function automatic logic [5:0] irq_vec(input rsx_irq_t r);
    if (r.nmi) irq_vec = VEC_NMI;
    else if (r.rx_queue_irq) irq_vec = VEC_RXQ;
    else if (r.tx_queue_empty_irq) irq_vec = VEC_TXE;
    else if (r.line_turnaround_irq) irq_vec = VEC_LTA;
    else if (r.bidir_pin_irq) irq_vec = VEC_BIDIR;
    else irq_vec = VEC_TMR;
  endfunction : irq_vec

  // Bus state
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  // Execution state
  rsx_state_t st_q, st_d;
  logic [1:0] tcnt_q, tcnt_d;
  logic [31:0] cmd_q, cmd_d;
  logic hw_q, hw_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] ibr_q, ibr_d;
  rsx_flags_t flg_q, flg_d;
  logic gie_q, gie_d;
  logic [1:0] bank_q, bank_d;
  logic [2:0] fsel_q, fsel_d;
  logic [7:0] rf_q [32];
  logic [7:0] rf_d [32];
  logic [7:0] acc_q [2];
  logic [7:0] acc_d [2];
  logic [15:0] idx_q [4];
  logic [15:0] idx_d [4];
  rsx_dmem_t dm_q, dm_d;
  rsx_irq_t iack_q, iack_d;

  // Decoded command and datapath wires
  logic bus_req, wr_en;
  logic [7:0] adr;
  rsx_op_t op;
  logic [4:0] src, dst;
  logic [3:0] lim;
  logic [7:0] imm;
  logic [1:0] mode, ptr, gsel;
  logic didx, rflag, cmd_go, irq_go;
  logic [7:0] opa, opb, alu_res;
  rsx_flags_t alu_flg;
  logic push, pop;
  rsx_stk_t push_data, top;
  logic [3:0] sp;
  logic [31:0] ic;
  logic [31:0] cmd_new;

  assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  assign wr_en = bus_req & wb_req_i.we;
  assign adr = wb_req_i.adr;
  assign op = rsx_op_t'(cmd_q[F_OP +: 4]);
  assign src = cmd_q[F_SRC +: 5];
  assign dst = cmd_q[F_DST +: 5];
  assign lim = cmd_q[F_DST +: 4];
  assign didx = cmd_q[F_DIDX];
  assign mode = cmd_q[F_MODE +: 2];
  assign ptr = cmd_q[F_PTR +: 2];
  assign imm = cmd_q[F_IMM +: 8];
  assign gsel = cmd_q[F_G +: 2];
  assign rflag = cmd_q[F_RF];
  assign ic = idx_calc(mode, idx_q[ptr]);
  assign cmd_new = lane_merge(cmd_q, wb_req_i.dat, wb_req_i.sel);
  assign cmd_go = wr_en & (adr == ADR_CMD) & (st_q == ST_IDLE);
  assign irq_go = (st_q == ST_IDLE) & ~cmd_go & (irq_req_i.nmi
                  | (gie_q & (|irq_req_i[4:0])));

  // Operand selection
  always_comb begin
    opa = 8'h00;
    opb = imm;
    case (op)
      OP_SUB_IMM, OP_XOR_IMM: opa = rf_q[{1'b0, lim}];
      OP_CIRC_RIGHT, OP_LEFT_SHIFT, OP_RIGHT_SHIFT: opa = rf_q[dst];
      OP_MINUS_ACC, OP_MINUS_BORROW_ACC, OP_EXCLUSIVE_OR_ACC: begin
        opa = rf_q[src];
        opb = acc_q[bank_q[0]];
      end
      default: ;
    endcase
  end

  rsx_alu u_alu (
    .op_i(op),
    .a_i(opa),
    .b_i(opb),
    .cnt_i(imm[2:0]),
    .flg_i(flg_q),
    .res_o(alu_res),
    .flg_o(alu_flg)
  );

  // Context saved by a trap; interrupts resume at the current address
  assign push_data = '{pc: hw_q ? pc_q : pc_q + 16'h0001, global_irq_enable: gie_q,
                       flg: flg_q, bank: bank_q};

  rsx_stack u_stack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(push),
    .pop_i(pop),
    .wdata_i(push_data),
    .top_o(top),
    .ptr_o(sp)
  );

  // Bus answer and read mux
  always_comb begin
    ack_d = bus_req;
    rdat_d = 32'h0000_0000;
    if (bus_req) begin
      if (adr[ADR_RF_BIT]) begin
        rdat_d = {24'h000000, rf_q[adr[6:2]]};
      end else if (adr[7:4] == ADR_IDX[7:4]) begin
        rdat_d = {16'h0000, idx_q[adr[3:2]]};
      end else if (adr[7:3] == ADR_ACC[7:3]) begin
        rdat_d = {24'h000000, acc_q[adr[2]]};
      end else begin
        case (adr)
          ADR_CMD: rdat_d = cmd_q;
          ADR_STAT: begin
            rdat_d[S_BUSY] = (st_q == ST_EXEC);
            rdat_d[S_FLG +: 4] = flg_q;
            rdat_d[S_GIE] = gie_q;
            rdat_d[S_BANK +: 2] = bank_q;
            rdat_d[S_COND] = cond_pick(fsel_q, flg_q, xmit_status_reg_i);
            rdat_d[S_SP +: 4] = sp;
          end
          ADR_PC: rdat_d = {16'h0000, pc_q};
          ADR_IBR: rdat_d = {24'h000000, ibr_q};
          ADR_CTRL: rdat_d = {29'h0, fsel_q};
          default: rdat_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Register writes, sequencing and instruction commit
  always_comb begin
    st_d = st_q;
    tcnt_d = tcnt_q;
    cmd_d = cmd_q;
    hw_d = hw_q;
    pc_d = pc_q;
    ibr_d = ibr_q;
    flg_d = flg_q;
    gie_d = gie_q;
    bank_d = bank_q;
    fsel_d = fsel_q;
    rf_d = rf_q;
    acc_d = acc_q;
    idx_d = idx_q;
    dm_d = '0;
    iack_d = '0;
    push = 1'b0;
    pop = 1'b0;
    if (wr_en && wb_req_i.sel[0]) begin
      if (adr[ADR_RF_BIT]) begin
        rf_d[adr[6:2]] = wb_req_i.dat[7:0];
      end else if (adr[7:4] == ADR_IDX[7:4]) begin
        idx_d[adr[3:2]] = 16'(lane_merge({16'h0000, idx_q[adr[3:2]]},
                                         wb_req_i.dat, wb_req_i.sel));
      end else if (adr[7:3] == ADR_ACC[7:3]) begin
        acc_d[adr[2]] = wb_req_i.dat[7:0];
      end else begin
        case (adr)
          ADR_STAT: begin
            flg_d = wb_req_i.dat[S_FLG +: 4];
            gie_d = wb_req_i.dat[S_GIE];
            bank_d = wb_req_i.dat[S_BANK +: 2];
          end
          ADR_PC: pc_d = wb_req_i.dat[15:0];
          ADR_IBR: ibr_d = wb_req_i.dat[7:0];
          ADR_CTRL: fsel_d = wb_req_i.dat[2:0];
          default: ;
        endcase
      end
    end
    case (st_q)
      ST_IDLE: begin
        if (cmd_go) begin
          cmd_d = cmd_new;
          hw_d = 1'b0;
          st_d = ST_EXEC;
          tcnt_d = TS_REG - 2'h1;
          if (cmd_new[F_DIDX] && (cmd_new[F_OP +: 4] == OP_MINUS_BORROW_ACC
              || cmd_new[F_OP +: 4] == OP_MINUS_ACC
              || cmd_new[F_OP +: 4] == OP_EXCLUSIVE_OR_ACC)) begin
            tcnt_d = TS_MEM - 2'h1;
          end
        end else if (irq_go) begin
          cmd_d = '0;
          cmd_d[F_OP +: 4] = OP_TRAP;
          cmd_d[F_IMM +: 8] = {2'b00, irq_vec(irq_req_i)};
          cmd_d[F_RF] = 1'b1;
          iack_d = irq_req_i.nmi ? rsx_irq_t'(6'h20)
                   : rsx_irq_t'(6'h01 << (3'h4 - 3'(irq_vec(irq_req_i)
                     >> 2) + 3'h1));
          hw_d = 1'b1;
          st_d = ST_EXEC;
          tcnt_d = TS_REG - 2'h1;
        end
      end
      ST_EXEC: begin
        if (tcnt_q != 2'h0) begin
          tcnt_d = tcnt_q - 2'h1;
        end else begin
          st_d = ST_IDLE;
          pc_d = pc_q + 16'h0001;
          case (op)
            OP_POP_JUMP: begin
              pop = 1'b1;
              pc_d = top.pc;
              case (gsel)
                2'h1: gie_d = top.global_irq_enable;
                2'h2: gie_d = 1'b1;
                2'h3: gie_d = 1'b0;
                default: ;
              endcase
              if (rflag) begin
                flg_d = top.flg;
                bank_d = top.bank;
              end
            end
            OP_TRAP: begin
              push = 1'b1;
              pc_d = {ibr_q, 2'b00, imm[5:0]};
              if (rflag) begin
                gie_d = 1'b0;
              end
            end
            OP_SUB_IMM, OP_XOR_IMM: begin
              rf_d[{1'b0, lim}] = alu_res;
              flg_d = alu_flg;
            end
            OP_CIRC_RIGHT, OP_LEFT_SHIFT, OP_RIGHT_SHIFT: begin
              rf_d[dst] = alu_res;
              flg_d = alu_flg;
            end
            OP_MINUS_ACC, OP_MINUS_BORROW_ACC, OP_EXCLUSIVE_OR_ACC: begin
              flg_d = alu_flg;
              if (didx) begin
                idx_d[ptr] = ic[15:0];
                dm_d = '{we: 1'b1, addr: ic[31:16], data: alu_res};
              end else begin
                rf_d[dst] = alu_res;
              end
            end
            default: ;
          endcase
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      tcnt_q <= 2'h0;
      cmd_q <= 32'h0000_0000;
      hw_q <= 1'b0;
      pc_q <= 16'h0000;
      ibr_q <= 8'h00;
      flg_q <= '0;
      gie_q <= 1'b0;
      bank_q <= 2'h0;
      fsel_q <= 3'h0;
      dm_q <= '0;
      iack_q <= '0;
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= 8'h00;
      end
      acc_q[0] <= 8'h00;
      acc_q[1] <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        idx_q[i] <= 16'h0000;
      end
    end else begin
      st_q <= st_d;
      tcnt_q <= tcnt_d;
      cmd_q <= cmd_d;
      hw_q <= hw_d;
      pc_q <= pc_d;
      ibr_q <= ibr_d;
      flg_q <= flg_d;
      gie_q <= gie_d;
      bank_q <= bank_d;
      fsel_q <= fsel_d;
      dm_q <= dm_d;
      iack_q <= iack_d;
      rf_q <= rf_d;
      acc_q <= acc_d;
      idx_q <= idx_d;
    end
  end

  // Outputs from flip-flops
  assign wb_rsp_o = '{ack: ack_q, dat: rdat_q};
  assign dmem_o = dm_q;
  assign irq_ack_o = iack_q;

endmodule : rsx_core

/* File: rsx_core_properties.sv */
`timescale 1ns/1ps
module rsx_core_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input rsx_pkg::rsx_wb_req_t wb_req_i,
  input rsx_pkg::rsx_wb_rsp_t wb_rsp_o,
  input rsx_pkg::rsx_irq_t irq_req_i,
  input rsx_pkg::rsx_irq_t irq_ack_o,
  input rsx_pkg::rsx_dmem_t dmem_o
);
  import rsx_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take, cmd_wr, mem_cmd;
  // Accepted bus requests and indexed accumulator commands
  assign take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign cmd_wr = take && wb_req_i.we && wb_req_i.adr == ADR_CMD;
  assign mem_cmd = cmd_wr && wb_req_i.dat[F_DIDX] &&
    wb_req_i.dat[3:0] inside {4'h2, 4'h6, 4'h9};
  // Indexed store: three quiet cycles, one write pulse
  sequence s_quiet;
    !dmem_o.we [*3];
  endsequence
  sequence s_store;
    s_quiet ##1 dmem_o.we ##1 !dmem_o.we;
  endsequence
  ack_follows_a: assert property (take |=> wb_rsp_o.ack)
    else $error("bus ack missing");
  ack_single_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("bus ack too long");
  idle_data_a: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
    else $error("read data outside ack");
  unmapped_zero_a: assert property (take && !wb_req_i.we &&
    wb_req_i.adr inside {[8'h38:8'h7f]} |=> wb_rsp_o.dat == 32'h0)
    else $error("unmapped read not zero");
  mem_store_a: assert property (mem_cmd |=> s_store)
    else $error("indexed store timing");
  store_cause_a: assert property (dmem_o.we |-> $past(mem_cmd, 4))
    else $error("store without indexed command");
  irq_onehot_a: assert property (irq_ack_o != 6'h0 |->
    $onehot(irq_ack_o))
    else $error("interrupt ack not one-hot");
  irq_cause_a: assert property (irq_ack_o != 6'h0 |->
    (irq_ack_o & $past(irq_req_i)) == irq_ack_o)
    else $error("interrupt ack without request");
  irq_nmi_first_a: assert property ($past(irq_req_i.nmi) &&
    irq_ack_o != 6'h0 |-> irq_ack_o.nmi)
    else $error("non-maskable not first");
  irq_no_cmd_a: assert property (cmd_wr |=> irq_ack_o == 6'h0)
    else $error("interrupt taken with command");
endmodule : rsx_core_properties

bind rsx_core rsx_core_properties rsx_core_properties_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .irq_req_i(irq_req_i), .irq_ack_o(irq_ack_o), .dmem_o(dmem_o));

/* File: rsx_core_tb_top.sv */
`timescale 1ns/1ps
module rsx_core_tb_top;
  import rsx_pkg::*;
  localparam logic [31:0] MST = 32'h0000f0ff;
  localparam logic [3:0] OPS [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h8, 4'h9};
  localparam logic [5:0] VT [6] = '{6'h1c, 6'h04, 6'h08, 6'h0c, 6'h10,
    6'h14};
  logic clk_i, rst_i, got, gp;
  rsx_wb_req_t req;
  rsx_wb_rsp_t rsp;
  rsx_xsr_t xsr;
  rsx_irq_t irq, iack;
  rsx_dmem_t dm;
  logic [15:0] got_a, iv;
  logic [7:0] got_d, a, b, ib;
  logic [3:0] op, f, f2;
  logic [1:0] bk, g;
  logic [2:0] k;
  logic [5:0] v;
  logic [4:0] s, d;
  logic [11:0] e;
  int error_cnt, cmp_count, cyc_cnt;
  logic [63:0] rd_q[$];
  logic [23:0] dm_q[$];

  rsx_core rsx_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .xmit_status_reg_i(xsr), .irq_req_i(irq),
    .irq_ack_o(iack), .dmem_o(dm));
  rsx_dmem_model rsx_dmem_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .dmem_i(dm), .got_o(got), .got_addr_o(got_a), .got_data_o(got_d));

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] gv, input logic [31:0] ev);
    cmp_count++;
    if (gv !== ev) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, gv, ev);
    end
  endtask : check

  task automatic print_verdict;
    if (rd_q.size() != 0 || dm_q.size() != 0) error_cnt++;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Classic single bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] ad,
      input logic [31:0] dv);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, ad, 4'hf, dv};
    do @(posedge clk_i); while (!rsp.ack);
    req <= '0;
  endtask : wb

  task automatic rd(input logic [7:0] ad, input logic [31:0] m,
      input logic [31:0] ev);
    rd_q.push_back({m, ev & m});
    wb(1'b0, ad, 32'h0);
  endtask : rd

  task automatic cmd(input logic [31:0] c);
    wb(1'b1, ADR_CMD, c);
    repeat (3) @(posedge clk_i);
  endtask : cmd

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  function automatic logic [31:0] st(input logic [3:0] fl, input logic ge,
      input logic [1:0] bs, input logic [3:0] sp);
    return {16'h0, sp, 4'h0, bs, ge, fl, 1'b0};
  endfunction : st

  function automatic logic [31:0] mk(input logic [3:0] o,
      input logic [4:0] sr, input logic [4:0] ds, input logic x,
      input logic [1:0] m, input logic [1:0] p, input logic [7:0] im,
      input logic [1:0] gg, input logic r);
    return {2'h0, r, gg, im, p, m, x, ds, sr, o};
  endfunction : mk

  // Reference result and flags {n, z, c, v, result}
  function automatic logic [11:0] alu(input logic [3:0] o,
      input logic [7:0] x, input logic [7:0] y, input logic [2:0] n,
      input logic [3:0] fi);
    logic [15:0] t;
    logic [8:0] r;
    logic c, w;
    c = fi[1];
    w = fi[0];
    t = 16'h0;
    case (o)
      4'h1: t = {x, x} >> n;
      4'h3: t = {8'h0, x} << n;
      4'h4: t = {x, 8'h0} >> n;
      4'h8, 4'h9: r = {1'b0, x ^ y};
      default: r = {1'b0, x} - {1'b0, y} - {8'h0, o == 4'h2 && fi[1]};
    endcase
    if (o == 4'h1) r = {t[7], t[7:0]};
    if (o == 4'h3) r = t[8:0];
    if (o == 4'h4) r = {t[7], t[15:8]};
    if (o inside {4'h1, 4'h3, 4'h4} && n != 3'h0) c = r[8];
    if (o inside {4'h2, 4'h5, 4'h6}) begin
      c = r[8];
      w = (x[7] != y[7]) && (r[7] != x[7]);
    end
    return {r[7], r[7:0] == 8'h0, c, w, r[7:0]};
  endfunction : alu

  // Compare results against the oldest noted expectation
  always @(posedge clk_i) begin
    if (rsp.ack && !req.we && rd_q.size() != 0) begin
      check(rsp.dat & rd_q[0][63:32], rd_q[0][31:0]);
      void'(rd_q.pop_front());
    end
    if (got && dm_q.size() != 0) begin
      check({8'h0, got_a, got_d}, {8'h0, dm_q.pop_front()});
    end
  end

  // Hang guard
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    req = '0;
    xsr = '0;
    irq = '0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    void'($urandom(32'h7d0f3c8a));
    rd(ADR_STAT, 32'hffff, 32'h0);
    rd(ADR_PC, 32'hffff, 32'h0);
    wb(1'b1, 8'h40, $urandom);
    rd(8'h40, 32'hffffffff, 32'h0);
    wb(1'b1, ADR_IBR, 32'hffffffa5);
    rd(ADR_IBR, 32'hffffffff, 32'ha5);
    done("map");
    for (int i = 0; i < 16; i++) begin
      f = 4'($urandom);
      xsr <= 4'($urandom);
      wb(1'b1, ADR_STAT, st(f, 1'b0, 2'h0, 4'h0));
      wb(1'b1, ADR_CTRL, 32'(i % 8));
      a = {xsr.tx_queue_full, xsr.rx_data_ready, xsr.rx_error,
        xsr.rx_active, f[3], f[0], f[1], f[2]};
      rd(ADR_STAT, 32'h100, {23'h0, a[i % 8], 8'h0});
    end
    done("selector");
    for (int i = 0; i < 48; i++) begin
      op = OPS[i % 8];
      s = 5'($urandom_range(15));
      d = op inside {4'h2, 4'h6, 4'h9} ? s ^ 5'h11 : s;
      {a, b, k, f, bk} = 25'($urandom);
      if (i % 6 == 0) b = a;
      wb(1'b1, ADR_STAT, st(f, 1'b0, bk, 4'h0));
      wb(1'b1, {1'b1, s, 2'h0}, {24'h0, a});
      wb(1'b1, ADR_ACC | {5'h0, bk[0], 2'h0}, {24'h0, b});
      if (op inside {4'h1, 4'h3, 4'h4}) b = {5'h0, k};
      e = alu(op, a, b, k, f);
      wb(1'b1, ADR_CMD, mk(op, s, d, 1'b0, 2'h0, 2'h0, b, 2'h0, 1'b0));
      rd({1'b1, d, 2'h0}, 32'hff, {24'h0, e[7:0]});
      rd(ADR_STAT, MST, st(e[11:8], 1'b0, bk, 4'h0));
    end
    done("alu");
    for (int m = 0; m < 4; m++) begin
      {a, b, f, iv} = 36'({$urandom, $urandom});
      op = m == 1 ? 4'h2 : (m == 2 ? 4'h9 : 4'h6);
      s = 5'(m + 3);
      wb(1'b1, ADR_STAT, st(f, 1'b0, 2'h0, 4'h0));
      wb(1'b1, ADR_IDX | 8'(4 * (3 - m)), {16'h0, iv});
      wb(1'b1, {1'b1, s, 2'h0}, {24'h0, a});
      wb(1'b1, ADR_ACC, {24'h0, b});
      e = alu(op, a, b, 3'h0, f);
      dm_q.push_back({m == 3 ? iv + 16'h1 : iv, e[7:0]});
      wb(1'b1, ADR_CMD, mk(op, s, 5'h0, 1'b1, 2'(m), 2'(3 - m), 8'h0,
        2'h0, 1'b0));
      rd(ADR_STAT, 32'h1, 32'h1);
      iv = m == 0 ? iv - 16'h1 : (m == 1 ? iv : iv + 16'h1);
      rd(ADR_IDX | 8'(4 * (3 - m)), 32'hffff, {16'h0, iv});
      rd(ADR_STAT, MST, st(e[11:8], 1'b0, 2'h0, 4'h0));
    end
    done("indexed");
    ib = 8'($urandom);
    wb(1'b1, ADR_IBR, {24'h0, ib});
    for (int j = 0; j < 8; j++) begin
      g = 2'(j);
      {f, f2, bk, gp, v, iv} = 33'({$urandom, $urandom});
      wb(1'b1, ADR_STAT, st(f, gp, bk, 4'h0));
      wb(1'b1, ADR_PC, {16'h0, iv});
      cmd(mk(4'h7, 5'h0, 5'h0, 1'b0, 2'h0, 2'h0, {2'h0, v}, 2'h0, j[0]));
      rd(ADR_PC, 32'hffff, {16'h0, ib, 2'h0, v});
      rd(ADR_STAT, MST, st(f, gp & !j[0], bk, 4'h1));
      wb(1'b1, ADR_STAT, st(f2, !gp, ~bk, 4'h0));
      cmd(mk(4'h0, 5'h0, 5'h0, 1'b0, 2'h0, 2'h0, 8'h0, g, j[2]));
      rd(ADR_PC, 32'hffff, {16'h0, iv + 16'h1});
      a[0] = g == 2'h0 ? !gp : (g == 2'h1 ? gp : !g[0]);
      f = j[2] ? f : f2;
      bk = j[2] ? bk : ~bk;
      rd(ADR_STAT, MST, st(f, a[0], bk, 4'h0));
    end
    done("trap");
    for (int q = 0; q < 6; q++) begin
      wb(1'b1, ADR_STAT, st(4'h0, q != 0, 2'h0, 4'h0));
      irq <= 6'h20 >> q;
      do @(posedge clk_i); while (iack == 6'h0);
      check({26'h0, iack}, 32'h20 >> q);
      irq <= 6'h0;
      repeat (3) @(posedge clk_i);
      rd(ADR_PC, 32'hffff, {16'h0, ib, 2'h0, VT[q]});
      cmd(mk(4'h0, 5'h0, 5'h0, 1'b0, 2'h0, 2'h0, 8'h0, 2'h0, 1'b0));
    end
    wb(1'b1, ADR_STAT, 32'h0);
    wb(1'b1, ADR_PC, 32'h1234);
    irq <= 6'h01;
    repeat (6) @(posedge clk_i);
    rd(ADR_PC, 32'hffff, 32'h1234);
    irq <= 6'h0;
    done("interrupts");
    repeat (8) @(posedge clk_i);
    print_verdict();
  end
endmodule : rsx_core_tb_top

/* File: rsx_dmem_model.sv */
`timescale 1ns/1ps
module rsx_dmem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port of the core
  input rsx_pkg::rsx_dmem_t dmem_i,
  // Last stored byte, flagged for one cycle
  output logic got_o,
  output logic [15:0] got_addr_o,
  output logic [7:0] got_data_o
);
  import rsx_pkg::*;
  logic [7:0] mem_q [logic [15:0]];
  // Store pulsed writes and report the byte held in memory
  always @(posedge clk_i) begin
    if (!rst_i && dmem_i.we) begin
      mem_q[dmem_i.addr] = dmem_i.data;
    end
    got_o <= !rst_i && dmem_i.we;
    got_addr_o <= dmem_i.addr;
    got_data_o <= mem_q.exists(dmem_i.addr) ? mem_q[dmem_i.addr] : 8'h00;
  end
endmodule : rsx_dmem_model

/* File: rsx_pkg.sv */
package rsx_pkg;

  // Register byte offsets
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_PC = 8'h08;
  localparam logic [7:0] ADR_IBR = 8'h0c;
  localparam logic [7:0] ADR_CTRL = 8'h10;
  localparam logic [7:0] ADR_IDX = 8'h20;
  localparam logic [7:0] ADR_ACC = 8'h30;
  localparam int ADR_RF_BIT = 7;

  // Command word fields
  localparam int F_OP = 0;
  localparam int F_SRC = 4;
  localparam int F_DST = 9;
  localparam int F_DIDX = 14;
  localparam int F_MODE = 15;
  localparam int F_PTR = 17;
  localparam int F_IMM = 19;
  localparam int F_G = 27;
  localparam int F_RF = 29;

  // Status word fields
  localparam int S_BUSY = 0;
  localparam int S_FLG = 1;
  localparam int S_GIE = 5;
  localparam int S_BANK = 6;
  localparam int S_COND = 8;
  localparam int S_SP = 12;

  // Execution lengths in T-states
  localparam logic [1:0] TS_REG = 2'h2;
  localparam logic [1:0] TS_MEM = 2'h3;

  // Hardware interrupt vectors
  localparam logic [5:0] VEC_NMI = 6'h1c;
  localparam logic [5:0] VEC_RXQ = 6'h04;
  localparam logic [5:0] VEC_TXE = 6'h08;
  localparam logic [5:0] VEC_LTA = 6'h0c;
  localparam logic [5:0] VEC_BIDIR = 6'h10;
  localparam logic [5:0] VEC_TMR = 6'h14;

  localparam int STK_DEPTH = 16;

  typedef enum logic [3:0] {
    OP_POP_JUMP = 4'h0,
    OP_CIRC_RIGHT = 4'h1,
    OP_MINUS_BORROW_ACC = 4'h2,
    OP_LEFT_SHIFT = 4'h3,
    OP_RIGHT_SHIFT = 4'h4,
    OP_SUB_IMM = 4'h5,
    OP_MINUS_ACC = 4'h6,
    OP_TRAP = 4'h7,
    OP_XOR_IMM = 4'h8,
    OP_EXCLUSIVE_OR_ACC = 4'h9
  } rsx_op_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } rsx_flags_t;

  typedef struct packed {
    logic [15:0] pc;
    logic global_irq_enable;
    rsx_flags_t flg;
    logic [1:0] bank;
  } rsx_stk_t;

  typedef struct packed {
    logic rx_active;
    logic rx_error;
    logic rx_data_ready;
    logic tx_queue_full;
  } rsx_xsr_t;

  typedef struct packed {
    logic nmi;
    logic rx_queue_irq;
    logic tx_queue_empty_irq;
    logic line_turnaround_irq;
    logic bidir_pin_irq;
    logic timer_expiry_irq;
  } rsx_irq_t;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } rsx_dmem_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rsx_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rsx_wb_rsp_t;

endpackage : rsx_pkg

/* File: rsx_stack.sv */
`timescale 1ns/1ps
module rsx_stack (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Push and pop
  input wire logic push_i,
  input wire logic pop_i,
  input rsx_pkg::rsx_stk_t wdata_i,
  // Top entry and pointer
  output rsx_pkg::rsx_stk_t top_o,
  output logic [3:0] ptr_o
);
  import rsx_pkg::*;

  rsx_stk_t mem_q [STK_DEPTH];
  rsx_stk_t mem_d [STK_DEPTH];
  logic [3:0] ptr_q;
  logic [3:0] ptr_d;

  // Pointer moves; push wins over pop
  always_comb begin
    mem_d = mem_q;
    ptr_d = ptr_q;
    if (push_i) begin
      mem_d[ptr_q] = wdata_i;
      ptr_d = ptr_q + 4'h1;
    end else if (pop_i) begin
      ptr_d = ptr_q - 4'h1;
    end
  end

  // Stack storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= 4'h0;
      for (int i = 0; i < STK_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      ptr_q <= ptr_d;
      mem_q <= mem_d;
    end
  end

  assign top_o = mem_q[ptr_q - 4'h1];
  assign ptr_o = ptr_q;

endmodule : rsx_stack
